// [src/psl_port_split.v]
// port split control with link stall watchdog for downstream ports 4 and 5
`timescale 1ns/100ps
`include "psl_port_split_regs.vh"

module psl_port_split #(
    parameter CYC_PER_MS = `PSL_CLK_KHZ
) (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire [15:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire i_reg_wr,
    input wire i_reg_rd,
    output reg [7:0] o_reg_rdata,
    input wire i_otp_load,
    input wire [2:0] i_otp_link_timeout,
    input wire [3:0] i_link_state_status_p4,
    input wire [3:0] i_link_state_status_p5,
    input wire i_legacy_port_power_p4,
    input wire i_legacy_port_power_p5,
    output reg o_legacy_port_power_pin_p4,
    output reg o_legacy_port_power_pin_p5,
    output reg o_gpio66,
    output reg o_gpio66_oe,
    output reg o_gpio5,
    output reg o_gpio5_oe,
    output reg o_gpio6,
    output reg o_gpio6_oe,
    output reg o_gpio4,
    output reg o_gpio4_oe
);

//----------------------------------------------------------------------
// constants
//----------------------------------------------------------------------
localparam integer PRE_MAX_I = CYC_PER_MS - 1;
localparam [19:0] PRE_MAX = PRE_MAX_I[19:0];
localparam [1:0] ST_MON = 2'b01;
localparam [1:0] ST_LOW = 2'b10;

//----------------------------------------------------------------------
// functions
//----------------------------------------------------------------------
// timeout code to milliseconds, zero means no timeout
function [11:0] tmo_ms;
    input [2:0] code;
    begin
        case (code)
            3'h1: tmo_ms = `PSL_TMO_MS_1;
            3'h2: tmo_ms = `PSL_TMO_MS_2;
            3'h3: tmo_ms = `PSL_TMO_MS_3;
            3'h4: tmo_ms = `PSL_TMO_MS_4;
            3'h5: tmo_ms = `PSL_TMO_MS_5;
            3'h6: tmo_ms = `PSL_TMO_MS_6;
            default: tmo_ms = 12'd0;
        endcase
    end
endfunction

function is_stuck_state;
    input [3:0] st;
    begin
        is_stuck_state = (st >= `PSL_LINK_STUCK_LO) &&
            (st <= `PSL_LINK_STUCK_HI);
    end
endfunction

// register address to one-hot hit vector; unmapped gives zero
function [4:0] addr_hit;
    input [15:0] a;
    begin
        if (a == `PSL_ADDR_SPLIT_ENABLE) begin
            addr_hit = 5'h01;
        end else if (a == `PSL_ADDR_P4_PIN_SEL) begin
            addr_hit = 5'h02;
        end else if (a == `PSL_ADDR_P5_PIN_SEL) begin
            addr_hit = 5'h04;
        end else if (a == `PSL_ADDR_LINK_TIMEOUT) begin
            addr_hit = 5'h08;
        end else if (a == `PSL_ADDR_TOGGLE_TIME) begin
            addr_hit = 5'h10;
        end else begin
            addr_hit = 5'h00;
        end
    end
endfunction

// a pin is driven only for its exact select code
function pin_hit;
    input en;
    input [7:0] sel;
    input [7:0] code;
    begin
        pin_hit = en && (sel == code);
    end
endfunction

//----------------------------------------------------------------------
// registers
//----------------------------------------------------------------------
reg [7:1] split_enable;
reg [7:0] port4_split_pin_select;
reg [7:0] port5_split_pin_select;
reg [2:0] split_link_timeout;
reg [7:0] split_toggle_time;
reg [7:1] next_split_enable;
reg [7:0] next_p4_pin_select;
reg [7:0] next_p5_pin_select;
reg [2:0] next_link_timeout;
reg [7:0] next_toggle_time;
wire [4:0] reg_hit = addr_hit(i_reg_addr);

// a write and an otp load in one cycle: the otp value wins
always @* begin
    next_split_enable = split_enable;
    next_p4_pin_select = port4_split_pin_select;
    next_p5_pin_select = port5_split_pin_select;
    next_link_timeout = split_link_timeout;
    next_toggle_time = split_toggle_time;
    if (i_reg_wr) begin
        if (reg_hit[0]) begin
            next_split_enable = i_reg_wdata[7:1];
        end else if (reg_hit[1]) begin
            next_p4_pin_select = i_reg_wdata;
        end else if (reg_hit[2]) begin
            next_p5_pin_select = i_reg_wdata;
        end else if (reg_hit[3]) begin
            next_link_timeout = i_reg_wdata[2:0];
        end else if (reg_hit[4]) begin
            next_toggle_time = i_reg_wdata;
        end
    end
    if (i_otp_load) begin
        next_link_timeout = i_otp_link_timeout;
    end
end

always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        split_enable <= `PSL_RST_SPLIT_EN_BITS;
        port4_split_pin_select <= `PSL_RST_P4_PIN_SEL;
        port5_split_pin_select <= `PSL_RST_P5_PIN_SEL;
        split_link_timeout <= `PSL_RST_LINK_TIMEOUT;
        split_toggle_time <= `PSL_RST_TOGGLE_TIME;
    end else begin
        split_enable <= next_split_enable;
        port4_split_pin_select <= next_p4_pin_select;
        port5_split_pin_select <= next_p5_pin_select;
        split_link_timeout <= next_link_timeout;
        split_toggle_time <= next_toggle_time;
    end
end

//----------------------------------------------------------------------
// register reads
//----------------------------------------------------------------------
reg [7:0] next_rdata;

// read data holds between reads; unmapped addresses read as zero
always @* begin
    next_rdata = o_reg_rdata;
    if (i_reg_rd) begin
        if (reg_hit[0]) begin
            next_rdata = {split_enable, 1'b0};
        end else if (reg_hit[1]) begin
            next_rdata = port4_split_pin_select;
        end else if (reg_hit[2]) begin
            next_rdata = port5_split_pin_select;
        end else if (reg_hit[3]) begin
            next_rdata = {5'h00, split_link_timeout};
        end else if (reg_hit[4]) begin
            next_rdata = split_toggle_time;
        end else begin
            next_rdata = 8'h00;
        end
    end
end

always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        o_reg_rdata <= 8'h00;
    end else begin
        o_reg_rdata <= next_rdata;
    end
end

//----------------------------------------------------------------------
// millisecond tick shared by both ports
//----------------------------------------------------------------------
reg [19:0] pre_cnt;
wire ms_tick = (pre_cnt == PRE_MAX);

always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        pre_cnt <= 20'h00000;
    end else if (ms_tick) begin
        pre_cnt <= 20'h00000;
    end else begin
        pre_cnt <= pre_cnt + 20'h00001;
    end
end

//----------------------------------------------------------------------
// per-port link watchdog; index 0 is port 4, index 1 is port 5
//----------------------------------------------------------------------
wire [1:0] port_en = {split_enable[`PSL_BIT_EN_P5],
    split_enable[`PSL_BIT_EN_P4]};
wire [11:0] tmo_lim = tmo_ms(split_link_timeout);
wire [11:0] low_lim = `PSL_TOGGLE_BASE_MS +
    `PSL_TOGGLE_STEP_MS * {4'h0, split_toggle_time};
wire [3:0] link_now [0:1];
assign link_now[0] = i_link_state_status_p4;
assign link_now[1] = i_link_state_status_p5;

reg [1:0] state [0:1];
reg [11:0] ms_cnt [0:1];
reg [3:0] link_last [0:1];
reg [1:0] pwr_on;
integer p;

//----------------------------------------------------------------------
// link qualifiers
//----------------------------------------------------------------------
// per-port conditions, worked out once so the state machine stays short
reg [1:0] stuck_hold;
reg [1:0] tmo_done;
reg [1:0] low_done;
integer q;

always @* begin
    stuck_hold = 2'b00;
    tmo_done = 2'b00;
    low_done = 2'b00;
    for (q = 0; q < 2; q = q + 1) begin
        stuck_hold[q] = (tmo_lim != 12'd0) &&
            is_stuck_state(link_now[q]) &&
            (link_now[q] == link_last[q]);
        tmo_done[q] = ms_tick && (ms_cnt[q] == tmo_lim - 12'd1);
        low_done[q] = ms_tick && (ms_cnt[q] == low_lim - 12'd1);
    end
end

always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        for (p = 0; p < 2; p = p + 1) begin
            state[p] <= ST_MON;
            ms_cnt[p] <= 12'd0;
            link_last[p] <= 4'h0;
        end
        pwr_on <= 2'b00;
    end else begin
        for (p = 0; p < 2; p = p + 1) begin
            link_last[p] <= link_now[p];
            if (!port_en[p]) begin
                state[p] <= ST_MON;
                ms_cnt[p] <= 12'd0;
                pwr_on[p] <= 1'b0;
            end else begin
                case (state[p])
                    ST_MON: begin
                        pwr_on[p] <= 1'b1;
                        if (!stuck_hold[p]) begin
                            ms_cnt[p] <= 12'd0;
                        end else if (tmo_done[p]) begin
                            state[p] <= ST_LOW;
                            pwr_on[p] <= 1'b0;
                            ms_cnt[p] <= 12'd0;
                        end else if (ms_tick) begin
                            ms_cnt[p] <= ms_cnt[p] + 12'd1;
                        end
                    end
                    ST_LOW: begin
                        pwr_on[p] <= 1'b0;
                        if (low_done[p]) begin
                            state[p] <= ST_MON;
                            pwr_on[p] <= 1'b1;
                            ms_cnt[p] <= 12'd0;
                        end else if (ms_tick) begin
                            ms_cnt[p] <= ms_cnt[p] + 12'd1;
                        end
                    end
                    default: begin
                        state[p] <= ST_MON;
                        ms_cnt[p] <= 12'd0;
                    end
                endcase
            end
        end
    end
end

//----------------------------------------------------------------------
// pin routing; split pins are output only, nothing is sensed
//----------------------------------------------------------------------
wire sel66 = pin_hit(port_en[0], port4_split_pin_select,
    `PSL_SEL_P4_PIN66);
wire sel5 = pin_hit(port_en[0], port4_split_pin_select, `PSL_SEL_P4_PIN5);
wire sel6 = pin_hit(port_en[1], port5_split_pin_select, `PSL_SEL_P5_PIN6);
wire sel4 = pin_hit(port_en[1], port5_split_pin_select, `PSL_SEL_P5_PIN4);

//----------------------------------------------------------------------
// split pin levels
//----------------------------------------------------------------------
reg next_gpio66;
reg next_gpio5;
reg next_gpio6;
reg next_gpio4;

// powered while monitoring, low during a reset pulse
always @* begin
    next_gpio66 = sel66 & pwr_on[0];
    next_gpio5 = sel5 & pwr_on[0];
    next_gpio6 = sel6 & pwr_on[1];
    next_gpio4 = sel4 & pwr_on[1];
end

always @(posedge i_clk_sys) begin
    if (!i_nrst) begin
        o_legacy_port_power_pin_p4 <= 1'b0;
        o_legacy_port_power_pin_p5 <= 1'b0;
        o_gpio66 <= 1'b0;
        o_gpio66_oe <= 1'b0;
        o_gpio5 <= 1'b0;
        o_gpio5_oe <= 1'b0;
        o_gpio6 <= 1'b0;
        o_gpio6_oe <= 1'b0;
        o_gpio4 <= 1'b0;
        o_gpio4_oe <= 1'b0;
    end else begin
        o_legacy_port_power_pin_p4 <= i_legacy_port_power_p4;
        o_legacy_port_power_pin_p5 <= i_legacy_port_power_p5;
        o_gpio66 <= next_gpio66;
        o_gpio66_oe <= sel66;
        o_gpio5 <= next_gpio5;
        o_gpio5_oe <= sel5;
        o_gpio6 <= next_gpio6;
        o_gpio6_oe <= sel6;
        o_gpio4 <= next_gpio4;
        o_gpio4_oe <= sel4;
    end
end

endmodule // psl_port_split

// [src/psl_port_split_regs.vh]
// register map, field layout and timing constants for the port split block
//----------------------------------------------------------------------
// What this block does
//----------------------------------------------------------------------
`ifndef PSL_PORT_SPLIT_REGS_VH
`define PSL_PORT_SPLIT_REGS_VH

//----------------------------------------------------------------------
// register offsets
//----------------------------------------------------------------------
`define PSL_ADDR_SPLIT_ENABLE 16'h3C48
`define PSL_ADDR_P4_PIN_SEL 16'h416E
`define PSL_ADDR_P5_PIN_SEL 16'h416F
`define PSL_ADDR_LINK_TIMEOUT 16'h4171
`define PSL_ADDR_TOGGLE_TIME 16'h4176

//----------------------------------------------------------------------
// reset values and fields
//----------------------------------------------------------------------
`define PSL_RST_SPLIT_ENABLE 8'h00
`define PSL_RST_SPLIT_EN_BITS 7'h00
`define PSL_RST_P4_PIN_SEL 8'h42
`define PSL_RST_P5_PIN_SEL 8'h06
`define PSL_RST_LINK_TIMEOUT 3'h5
`define PSL_RST_TOGGLE_TIME 8'h05
`define PSL_BIT_EN_P4 5
`define PSL_BIT_EN_P5 6
`define PSL_SEL_P4_PIN66 8'h42
`define PSL_SEL_P4_PIN5 8'h05
`define PSL_SEL_P5_PIN6 8'h06
`define PSL_SEL_P5_PIN4 8'h04

//----------------------------------------------------------------------
// link states judged as stuck
//----------------------------------------------------------------------
`define PSL_LINK_STUCK_LO 4'h4
`define PSL_LINK_STUCK_HI 4'h9

//----------------------------------------------------------------------
// timing, in milliseconds, and the clock rate
//----------------------------------------------------------------------
`define PSL_CLK_KHZ 250000
`define PSL_TMO_MS_1 12'd100
`define PSL_TMO_MS_2 12'd250
`define PSL_TMO_MS_3 12'd500
`define PSL_TMO_MS_4 12'd750
`define PSL_TMO_MS_5 12'd1000
`define PSL_TMO_MS_6 12'd2000
`define PSL_TOGGLE_BASE_MS 12'd350
`define PSL_TOGGLE_STEP_MS 12'd10

`endif

// [verif/psl_port_split_sva.sv]
// concurrent checks on the port split block ports
`timescale 1ns/100ps
module psl_port_split_sva (
    input wire i_clk_sys,
    input wire i_nrst,
    input wire [15:0] i_reg_addr,
    input wire i_reg_rd,
    input wire [7:0] o_reg_rdata,
    input wire i_legacy_port_power_p4,
    input wire o_legacy_port_power_pin_p4,
    input wire i_legacy_port_power_p5,
    input wire o_legacy_port_power_pin_p5,
    input wire o_gpio66,
    input wire o_gpio66_oe,
    input wire o_gpio5_oe,
    input wire o_gpio6_oe,
    input wire o_gpio4_oe
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);
    a_legacy_copy: assert property ($past(i_nrst) |->
        o_legacy_port_power_pin_p4 == $past(i_legacy_port_power_p4))
        else $error("legacy pin differs from its source");
    a_legacy_copy5: assert property ($past(i_nrst) |->
        o_legacy_port_power_pin_p5 == $past(i_legacy_port_power_p5))
        else $error("port 5 legacy pin differs from its source");
    a_unmapped_zero: assert property (i_reg_rd && !(i_reg_addr inside
        {16'h3C48, 16'h416E, 16'h416F, 16'h4171, 16'h4176}) |=>
        o_reg_rdata == 8'h00) else $error("unmapped read not zero");
    a_enable_bit0: assert property (i_reg_rd &&
        i_reg_addr == 16'h3C48 |=> !o_reg_rdata[0])
        else $error("enable bit 0 reads one");
    a_timeout_upper: assert property (i_reg_rd &&
        i_reg_addr == 16'h4171 |=> o_reg_rdata[7:3] == 5'h00)
        else $error("timeout upper bits not zero");
    a_rdata_hold: assert property (!i_reg_rd |=> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    a_p4_one_pin: assert property (!(o_gpio66_oe && o_gpio5_oe))
        else $error("both port 4 pins driven");
    a_p5_one_pin: assert property (!(o_gpio6_oe && o_gpio4_oe))
        else $error("both port 5 pins driven");
    a_undriven_low: assert property (!o_gpio66_oe |-> !o_gpio66)
        else $error("undriven pin shows high");
    c_pulse: cover property ($fell(o_gpio66) && o_gpio66_oe);
    c_opt_b: cover property ($rose(o_gpio4_oe));
    c_read: cover property (i_reg_rd ##1 !i_reg_rd);
endmodule // psl_port_split_sva
bind psl_port_split psl_port_split_sva u_sva (.*);

// [verif/psl_ss_device.sv]
// embedded superspeed device model powered by a split power pin
`timescale 1ns/100ps
module psl_ss_device (
    input wire i_clk_sys,
    input wire i_pwr,
    input wire [1:0] i_mode,
    output reg [3:0] o_link_state
);
    reg [7:0] cnt = 8'h00;
    initial o_link_state = 4'h5;
    // unpowered or broken: parked in receiver detect; mode 2 hops stuck states
    always @(posedge i_clk_sys) begin
        cnt <= cnt + 8'h01;
        if (!i_pwr || i_mode == 2'h0) begin
            o_link_state <= 4'h5;
        end else if (i_mode == 2'h1) begin
            o_link_state <= {2'h0, cnt[1:0]};
        end else begin
            o_link_state <= cnt[7] ? 4'h8 : 4'h7;
        end
    end
endmodule // psl_ss_device

// [verif/tb_port_split_link_watchdog.sv]
// self-checking bench for the port split block
`timescale 1ns/100ps
module tb_port_split_link_watchdog;
    localparam CPM = 4;
    reg clk = 0, nrst = 0, wr = 0, rd = 0, otp = 0, rd_d = 0, prev = 0;
    reg [15:0] addr = 16'h0000;
    reg [7:0] wdata = 8'h00;
    reg [2:0] otp_val = 3'h0;
    reg [1:0] leg = 2'h0, mode4 = 2'h0, mode5 = 2'h0;
    wire [7:0] rdata;
    wire [3:0] ls4, ls5;
    wire g66, g66e, g5, g5e, g6, g6e, g4, g4e;
    // a released pin is pulled low
    wire pin4 = (g66e & g66) | (g5e & g5);
    wire pin5 = (g6e & g6) | (g4e & g4);
    integer n_errors = 0, compares = 0, cyc = 0, t0 = 0, lo = 0;
    integer g, e, c, tt;
    integer q_rd[$], q_lo[$], q_ms[$];
    integer tmo_ms[1:6] = '{100, 250, 500, 750, 1000, 2000};
    reg [7:0] sel[1:6] = '{8'h42, 8'h06, 8'h05, 8'h04, 8'h42, 8'h04};
    always #2 clk = ~clk;
    always @(negedge clk) leg <= 2'($urandom);
    psl_port_split #(.CYC_PER_MS(CPM)) uut (
        .i_clk_sys(clk), .i_nrst(nrst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_otp_load(otp), .i_otp_link_timeout(otp_val),
        .i_link_state_status_p4(ls4), .i_link_state_status_p5(ls5),
        .i_legacy_port_power_p4(leg[0]), .i_legacy_port_power_p5(leg[1]),
        .o_legacy_port_power_pin_p4(), .o_legacy_port_power_pin_p5(),
        .o_gpio66(g66), .o_gpio66_oe(g66e), .o_gpio5(g5), .o_gpio5_oe(g5e),
        .o_gpio6(g6), .o_gpio6_oe(g6e), .o_gpio4(g4), .o_gpio4_oe(g4e));
    psl_ss_device dev4 (.i_clk_sys(clk), .i_pwr(pin4), .i_mode(mode4),
        .o_link_state(ls4));
    psl_ss_device dev5 (.i_clk_sys(clk), .i_pwr(pin5), .i_mode(mode5),
        .o_link_state(ls5));
    task chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
        compares = compares + 1;
        if (got !== ex) begin
            n_errors = n_errors + 1;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task wreg(input [15:0] a, input [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1;
        @(negedge clk);
        wr = 0;
    endtask
    task rreg(input [15:0] a, input [7:0] d);
        @(negedge clk);
        addr = a;
        rd = 1;
        q_rd.push_back(d);
        @(negedge clk);
        rd = 0;
    endtask
    task results;
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // monitor: read data, then pulse start and low width on either port
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc > 60000) begin
            n_errors = n_errors + 1;
            results;
        end
        if (rd_d) chk("read data", q_rd.pop_front(), rdata);
        rd_d = rd;
        if (prev && !(pin4 | pin5) && (g66e | g5e | g6e | g4e)) begin
            e = q_ms.pop_front();
            g = (cyc - t0) / CPM;
            chk("timeout ms", e, (g >= e - 1 && g <= e + 1) ? e : g);
            lo = 1;
        end else if (lo > 0 && (pin4 | pin5)) begin
            chk("low cycles", q_lo.pop_front(), lo);
            lo = 0;
        end else if (lo > 0) begin
            lo = lo + 1;
        end
        prev = pin4 | pin5;
    end
    initial begin
        void'($urandom(83411));
        repeat (10) @(negedge clk);
        nrst = 1;
        rreg(16'h3C48, 8'h00);
        rreg(16'h416E, 8'h42);
        rreg(16'h416F, 8'h06);
        rreg(16'h4171, 8'h05);
        rreg(16'h4176, 8'h05);
        rreg(16'h3C49, 8'h00);
        wreg(16'h3C48, 8'hFF);
        rreg(16'h3C48, 8'hFE);
        wreg(16'h3C48, 8'h00);
        wreg(16'h4171, 8'hFF);
        rreg(16'h4171, 8'h07);
        otp_val = 3'h2;
        otp = 1;
        @(negedge clk);
        otp = 0;
        rreg(16'h4171, 8'h02);
        $display("test registers done");
        for (c = 1; c <= 6; c = c + 1) begin
            tt = $urandom % 4;
            wreg(16'h4176, tt[7:0]);
            wreg(16'h4171, c[7:0]);
            wreg(c % 2 ? 16'h416E : 16'h416F, sel[c]);
            q_ms.push_back(tmo_ms[c]);
            q_lo.push_back((350 + 10 * tt) * CPM);
            t0 = cyc;
            wreg(16'h3C48, c % 2 ? 8'h20 : 8'h40);
            wait (q_lo.size() == 0);
            wreg(16'h3C48, 8'h00);
        end
        $display("test link timeout pulses done");
        mode4 = 2'h2;
        wreg(16'h4171, 8'h01);
        wreg(16'h416E, 8'h42);
        wreg(16'h3C48, 8'h20);
        for (c = 0; c < 4; c = c + 1) begin
            repeat (1000) @(negedge clk);
            chk("split pin held", 1, pin4);
            mode4 = c == 0 ? 2'h1 : 2'h0;
            wreg(16'h4171, c == 0 ? 8'h01 : (c == 1 ? 8'h00 : 8'h07));
        end
        wreg(16'h3C48, 8'h00);
        $display("test no pulse cases done");
        results;
    end
endmodule // tb_port_split_link_watchdog
